/* hdl/adcscp_cfg.svh */
`ifndef ADCSCP_CFG_SVH
`define ADCSCP_CFG_SVH
// How it works
// - Pins drive settings in parallel or hardware-serial mode
// - Software mode ignores hardware configuration pins
// - Port enabled only mode three, select low
// - Nine-bit shift, MSB first, bit eight starts
// - Ninth edge loads register, applies settings
// - Bits one and zero never written
// - Port accepts writes anytime up to 40 MHz
// - Port access time limits sample throughput
// - Port usable in all serial read modes
// - Reset clears register: 0-5 V, normal, twos
// - Start high begins load on first edge
// - Bits seven, six select input range
// - Bit five powers down, port stays usable
// - Bit two selects straight binary coding
// - Slave read may straddle next conversion start
`define ADCSCP_REG_W 9
`define ADCSCP_RESET_VAL 9'h000
`define ADCSCP_BIT_START 8
`define ADCSCP_BIT_BIPOLAR 7
`define ADCSCP_BIT_DOUBLE 6
`define ADCSCP_BIT_SLEEP 5
`define ADCSCP_BIT_CODE 2
`define ADCSCP_SERIAL_MODE 2'h3
`define ADCSCP_SHIFT_LEN 4'h9
`define ADCSCP_CFG_CLK_MAX_MHZ 40
`endif

/* hdl/adcscp_pkg.sv */
package adcscp_pkg;
  typedef enum logic [1:0] {
    ADCSCP_R0_5 = 2'h0,
    ADCSCP_R0_10 = 2'h1,
    ADCSCP_RPM5 = 2'h2,
    ADCSCP_RPM10 = 2'h3
  } adcscp_range_t;
endpackage : adcscp_pkg

/* hdl/adcscp_shift.sv */
`timescale 1ns/10ps
`include "adcscp_cfg.svh"
// Link-side shifter; runs on configuration clock edges, and deselect also clears the count.
module adcscp_shift
  import adcscp_pkg::*;
(
  // Link
  input wire logic cfg_serial_clock,
  input wire logic cfg_port_select_n,
  input wire logic cfg_serial_in,
  input wire logic clock_invert_select,
  input wire logic port_enable,
  input wire logic reset,
  // To core domain
  output logic [`ADCSCP_REG_W-1:0] word_q,
  output logic word_toggle_q
);
  logic [3:0] count_q;
  logic [`ADCSCP_REG_W-1:0] shift_q;
  logic [`ADCSCP_REG_W-1:0] shift_d;
  logic link_clk;

  // Inversion picks falling edge as active
  assign link_clk = cfg_serial_clock ^ clock_invert_select;
  assign shift_d = {shift_q[`ADCSCP_REG_W-2:0], cfg_serial_in};

  // Nine edges per word; host adds select lead and tail
  // No busy gating: a word is taken whenever it arrives
  // Deselect clears count, so a partial word never lands
  always_ff @(posedge link_clk or posedge cfg_port_select_n or posedge reset) begin
    if (reset || cfg_port_select_n) begin
      count_q <= 4'h0;
    end else if (port_enable) begin
      if (count_q == 4'h0 && !cfg_serial_in) begin
        count_q <= 4'h0;
      end else if (count_q == `ADCSCP_SHIFT_LEN - 4'h1) begin
        count_q <= 4'h0;
      end else begin
        count_q <= count_q + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      shift_q <= `ADCSCP_RESET_VAL;
    end else begin
      shift_q <= shift_d;
    end
  end

  // Word held stable until next toggle; core samples after sync
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      word_q <= `ADCSCP_RESET_VAL;
      word_toggle_q <= 1'b0;
    end else if (!cfg_port_select_n && port_enable && count_q == `ADCSCP_SHIFT_LEN - 4'h1) begin
      word_q <= shift_d;
      word_toggle_q <= ~word_toggle_q;
    end
  end
endmodule : adcscp_shift

/* hdl/adcscp_top.sv */
`timescale 1ns/10ps
`include "adcscp_cfg.svh"
module adcscp_top
  import adcscp_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Mode straps
  input wire logic [1:0] interface_mode,
  input wire logic pin_or_port_config_select,
  // Hardware configuration pins
  input wire logic range_bipolar_pin,
  input wire logic range_double_select,
  input wire logic sleep_request,
  input wire logic output_code_select,
  // Serial configuration port
  input wire logic cfg_serial_clock,
  input wire logic cfg_port_select_n,
  input wire logic cfg_serial_in,
  input wire logic clock_invert_select,
  // Applied settings
  output adcscp_range_t input_range,
  output logic power_down,
  output logic straight_binary,
  output logic port_enabled,
  output logic [`ADCSCP_REG_W-1:0] converter_setup_q
);
  logic [2:0] mode_s_q [0:2];
  logic [3:0] pin_s_q [0:2];
  logic [2:0] tog_s_q;
  logic [`ADCSCP_REG_W-1:0] word;
  logic word_toggle;
  logic [2:0] mode_now;
  logic [3:0] pin_now;
  logic sw_mode;
  logic [`ADCSCP_REG_W-1:0] setup_d;
  logic [`ADCSCP_REG_W-1:0] pin_word;
  logic word_seen;

  // Strap decode shared by the port gate and the core's mode flag
  function automatic logic port_mode_f(input logic [1:0] mode, input logic pin_sel);
    port_mode_f = (mode == `ADCSCP_SERIAL_MODE) && !pin_sel;
  endfunction : port_mode_f

  // Mode straps gate the link shifter directly; the port is idle while they move
  // Gate ignores read direction and master or slave reading
  assign port_enabled = port_mode_f(interface_mode, pin_or_port_config_select);
  // Result read path lives elsewhere; nothing here stalls it

  adcscp_shift adcscp_shift_inst (
    .cfg_serial_clock(cfg_serial_clock),
    .cfg_port_select_n(cfg_port_select_n),
    .cfg_serial_in(cfg_serial_in),
    .clock_invert_select(clock_invert_select),
    .port_enable(port_enabled),
    .reset(reset),
    .word_q(word),
    .word_toggle_q(word_toggle)
  );

  // Three-stage synchronisers; a mode or pin change counts when stages 2 and 3 agree, a word toggle when they differ
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 3; i++) begin
        mode_s_q[i] <= 3'h0;
        pin_s_q[i] <= 4'h0;
      end
      tog_s_q <= 3'h0;
    end else begin
      mode_s_q[0] <= {interface_mode, pin_or_port_config_select};
      pin_s_q[0] <= {range_bipolar_pin, range_double_select, sleep_request, output_code_select};
      tog_s_q <= {tog_s_q[1:0], word_toggle};
      for (int i = 1; i < 3; i++) begin
        mode_s_q[i] <= mode_s_q[i-1];
        pin_s_q[i] <= pin_s_q[i-1];
      end
    end
  end

  logic [2:0] mode_hold_q;
  logic [3:0] pin_hold_q;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_hold_q <= 3'h0;
      pin_hold_q <= 4'h0;
    end else begin
      if (mode_s_q[1] == mode_s_q[2]) begin
        mode_hold_q <= mode_s_q[2];
      end
      if (pin_s_q[1] == pin_s_q[2]) begin
        pin_hold_q <= pin_s_q[2];
      end
    end
  end

  assign mode_now = mode_hold_q;
  assign pin_now = pin_hold_q;
  assign sw_mode = port_mode_f(mode_now[2:1], mode_now[0]);
  assign word_seen = tog_s_q[2] != tog_s_q[1];

  always_comb begin
    pin_word = converter_setup_q;
    pin_word[`ADCSCP_BIT_BIPOLAR] = pin_now[3];
    pin_word[`ADCSCP_BIT_DOUBLE] = pin_now[2];
    pin_word[`ADCSCP_BIT_SLEEP] = pin_now[1];
    pin_word[`ADCSCP_BIT_CODE] = pin_now[0];
  end

  always_comb begin
    setup_d = converter_setup_q;
    if (!sw_mode) begin
      setup_d = pin_word;
    end else if (word_seen) begin
      // Pins ignored here reserved low bits kept
      setup_d = {word[`ADCSCP_REG_W-1:2], converter_setup_q[1:0]};
    end
  end

  // Reset to 0-5 V, awake, twos complement
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      converter_setup_q <= `ADCSCP_RESET_VAL;
    end else begin
      converter_setup_q <= setup_d;
    end
  end

  assign input_range = adcscp_range_t'(converter_setup_q[`ADCSCP_BIT_BIPOLAR:`ADCSCP_BIT_DOUBLE]);
  assign power_down = converter_setup_q[`ADCSCP_BIT_SLEEP];
  assign straight_binary = converter_setup_q[`ADCSCP_BIT_CODE];

  property p_reserved_kept;
    @(posedge ref_clk) disable iff (reset) sw_mode |=> converter_setup_q[1:0] == $past(converter_setup_q[1:0]);
  endproperty
  a_reserved_kept: assert property (p_reserved_kept) else $error("reserved bits changed");

  property p_pins_ignored;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && tog_s_q[2] == tog_s_q[1]) |=> $stable(converter_setup_q);
  endproperty
  a_pins_ignored: assert property (p_pins_ignored) else $error("setup moved without port write");

  property p_pins_applied;
    @(posedge ref_clk) disable iff (reset)
      !sw_mode |=> converter_setup_q[`ADCSCP_BIT_SLEEP] == $past(pin_now[1]);
  endproperty
  a_pins_applied: assert property (p_pins_applied) else $error("pin sleep not applied");

  property p_word_applied;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && tog_s_q[2] != tog_s_q[1]) |=> converter_setup_q[8:2] == $past(word[8:2]);
  endproperty
  a_word_applied: assert property (p_word_applied) else $error("port word not applied");

  property p_range_map;
    @(posedge ref_clk) disable iff (reset) input_range == adcscp_range_t'(converter_setup_q[7:6]);
  endproperty
  a_range_map: assert property (p_range_map) else $error("range decode wrong");

  property p_sleep_map;
    @(posedge ref_clk) disable iff (reset) power_down == converter_setup_q[5] && straight_binary == converter_setup_q[2];
  endproperty
  a_sleep_map: assert property (p_sleep_map) else $error("sleep or coding decode wrong");

  property p_port_gate;
    @(posedge ref_clk) disable iff (reset) pin_or_port_config_select |-> !port_enabled;
  endproperty
  a_port_gate: assert property (p_port_gate) else $error("port enabled in pin mode");

  property p_reset_clear;
    @(posedge ref_clk) $fell(reset) |-> converter_setup_q == 9'h000;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("setup not cleared by reset");

  property p_code_pin;
    @(posedge ref_clk) disable iff (reset)
      !sw_mode |=> converter_setup_q[`ADCSCP_BIT_CODE] == $past(pin_now[0]);
  endproperty
  a_code_pin: assert property (p_code_pin) else $error("pin coding not applied");

  property p_bipolar_pin;
    @(posedge ref_clk) disable iff (reset)
      !sw_mode |=> converter_setup_q[`ADCSCP_BIT_BIPOLAR] == $past(pin_now[3]);
  endproperty
  a_bipolar_pin: assert property (p_bipolar_pin) else $error("pin bipolar not applied");

  property p_double_pin;
    @(posedge ref_clk) disable iff (reset)
      !sw_mode |=> converter_setup_q[`ADCSCP_BIT_DOUBLE] == $past(pin_now[2]);
  endproperty
  a_double_pin: assert property (p_double_pin) else $error("pin double range not applied");

  property p_pin_mode_others;
    @(posedge ref_clk) disable iff (reset)
      !sw_mode |=> {converter_setup_q[8], converter_setup_q[4:3], converter_setup_q[1:0]} == $past({converter_setup_q[8], converter_setup_q[4:3], converter_setup_q[1:0]});
  endproperty
  a_pin_mode_others: assert property (p_pin_mode_others) else $error("pin mode moved other bits");

  property p_toggle_pulse;
    @(posedge ref_clk) disable iff (reset)
      word_seen |=> !word_seen;
  endproperty
  a_toggle_pulse: assert property (p_toggle_pulse) else $error("word strobe longer than a cycle");

  property p_mode_hold;
    @(posedge ref_clk) disable iff (reset)
      mode_s_q[1] != mode_s_q[2] |=> $stable(mode_hold_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode taken before stages agree");

  property p_pin_hold;
    @(posedge ref_clk) disable iff (reset)
      pin_s_q[1] != pin_s_q[2] |=> $stable(pin_hold_q);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pins taken before stages agree");

  property p_mode_take;
    @(posedge ref_clk) disable iff (reset)
      mode_s_q[1] == mode_s_q[2] |=> mode_hold_q == $past(mode_s_q[2]);
  endproperty
  a_mode_take: assert property (p_mode_take) else $error("agreed mode not taken");

  property p_pin_take;
    @(posedge ref_clk) disable iff (reset)
      pin_s_q[1] == pin_s_q[2] |=> pin_hold_q == $past(pin_s_q[2]);
  endproperty
  a_pin_take: assert property (p_pin_take) else $error("agreed pins not taken");

  property p_setup_in_reset;
    @(posedge ref_clk)
      reset |-> converter_setup_q == `ADCSCP_RESET_VAL;
  endproperty
  a_setup_in_reset: assert property (p_setup_in_reset) else $error("setup not held clear in reset");

  property p_port_gate_mode;
    @(posedge ref_clk) disable iff (reset)
      interface_mode != `ADCSCP_SERIAL_MODE |-> !port_enabled;
  endproperty
  a_port_gate_mode: assert property (p_port_gate_mode) else $error("port enabled outside serial mode");

  property p_sleep_port;
    @(posedge ref_clk) disable iff (reset)
      power_down && port_mode_f(interface_mode, pin_or_port_config_select) |-> port_enabled;
  endproperty
  a_sleep_port: assert property (p_sleep_port) else $error("port lost in power down");

  property p_sw_hold_pins;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && !word_seen && $changed(pin_now)) |=> $stable(converter_setup_q);
  endproperty
  a_sw_hold_pins: assert property (p_sw_hold_pins) else $error("pin move reached setup");

  property p_no_write_pin_mode;
    @(posedge ref_clk) disable iff (reset)
      (!sw_mode && word_seen) |=> converter_setup_q[8] == $past(converter_setup_q[8]);
  endproperty
  a_no_write_pin_mode: assert property (p_no_write_pin_mode) else $error("port word landed in pin mode");

  property p_code_word;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && word_seen) |=> straight_binary == $past(word[`ADCSCP_BIT_CODE]);
  endproperty
  a_code_word: assert property (p_code_word) else $error("port coding not applied");

  property p_sleep_word;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && word_seen) |=> power_down == $past(word[`ADCSCP_BIT_SLEEP]);
  endproperty
  a_sleep_word: assert property (p_sleep_word) else $error("port sleep not applied");

  property p_range_word;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && word_seen) |=> input_range == adcscp_range_t'($past(word[7:6]));
  endproperty
  a_range_word: assert property (p_range_word) else $error("port range not applied");

  property p_start_word;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && word_seen) |=> converter_setup_q[`ADCSCP_BIT_START] == $past(word[`ADCSCP_BIT_START]);
  endproperty
  a_start_word: assert property (p_start_word) else $error("start bit not stored");

  property p_rsv_word;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && word_seen) |=> converter_setup_q[4:3] == $past(word[4:3]);
  endproperty
  a_rsv_word: assert property (p_rsv_word) else $error("upper reserved bits not stored");

  property p_sw_no_pin_follow;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && !word_seen) |=> power_down == $past(power_down);
  endproperty
  a_sw_no_pin_follow: assert property (p_sw_no_pin_follow) else $error("sleep moved without word");

  property p_reset_range;
    @(posedge ref_clk)
      $fell(reset) |-> input_range == ADCSCP_R0_5 && !power_down && !straight_binary;
  endproperty
  a_reset_range: assert property (p_reset_range) else $error("reset settings wrong");

  property p_double_word;
    @(posedge ref_clk) disable iff (reset)
      (sw_mode && word_seen) |=> converter_setup_q[`ADCSCP_BIT_DOUBLE] == $past(word[`ADCSCP_BIT_DOUBLE]);
  endproperty
  a_double_word: assert property (p_double_word) else $error("port double range not applied");
endmodule : adcscp_top

/* tb/adcscp_host.sv */
`timescale 1ns/10ps
module adcscp_host (
  // Configuration link
  output logic cfg_serial_clock,
  output logic cfg_port_select_n,
  output logic cfg_serial_in
);
  initial begin
    cfg_serial_clock = 1'b0;
    cfg_port_select_n = 1'b1;
    cfg_serial_in = 1'b0;
  end
  // Clock parks at its idle level between frames
  // No busy phase modelled; writes fall outside conversion
  // Result reading is not modelled; config writes never wait on it
  task automatic send(input logic [8:0] w, input int n, input logic inv);
    cfg_serial_clock = inv;
    #7;
    cfg_port_select_n = 1'b0;
    for (int i = 8; i > 8 - n; i--) begin
      cfg_serial_in = w[i];
      #6 cfg_serial_clock = ~inv;
      #6 cfg_serial_clock = inv;
    end
    #6 cfg_port_select_n = 1'b1;
    // Released line must not keep the last bit
    cfg_serial_in = ~cfg_serial_in;
  endtask : send
endmodule : adcscp_host

/* tb/test_adc_serial_config_port.sv */
`timescale 1ns/10ps
module test_adc_serial_config_port;
  logic ref_clk, reset, pin_or_port_config_select, clock_invert_select;
  logic scl, ssel_n, sdin, power_down, straight_binary, port_enabled;
  logic [1:0] interface_mode, input_range;
  logic [3:0] pins;
  logic [8:0] converter_setup_q, exp_q;
  int n_errors = 0;
  int n_compared = 0;
  adcscp_host adcscp_host_inst (.cfg_serial_clock(scl), .cfg_port_select_n(ssel_n), .cfg_serial_in(sdin));
  adcscp_top adcscp_top_inst (.ref_clk(ref_clk), .reset(reset), .interface_mode(interface_mode),
    .pin_or_port_config_select(pin_or_port_config_select), .range_bipolar_pin(pins[3]),
    .range_double_select(pins[2]), .sleep_request(pins[1]), .output_code_select(pins[0]),
    .cfg_serial_clock(scl), .cfg_port_select_n(ssel_n), .cfg_serial_in(sdin),
    .clock_invert_select(clock_invert_select), .input_range(input_range), .power_down(power_down),
    .straight_binary(straight_binary), .port_enabled(port_enabled), .converter_setup_q(converter_setup_q));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [8:0] w, input int n, input logic inv);
    clock_invert_select = inv;
    adcscp_host_inst.send(w, n, inv);
    tick(10);
  endtask : wr
  task automatic t_serial();
    logic [8:0] w;
    for (int i = 0; i < 4; i++) begin
      w = {1'b1, i[1:0], ~i[0], i[1], i[0], i[1], 2'h3};
      wr(w, 9, i[0]);
      exp_q = {w[8:2], 2'h0};
      chk(converter_setup_q, exp_q);
      chk({7'h0, input_range}, {7'h0, w[7:6]});
      chk({8'h0, power_down}, {8'h0, w[5]});
      chk({8'h0, straight_binary}, {8'h0, w[2]});
    end
  endtask : t_serial
  task automatic t_refuse();
    wr(9'h1E4, 5, 1'b0);
    chk(converter_setup_q, exp_q);
    wr(9'h0E4, 9, 1'b0);
    chk(converter_setup_q, exp_q);
  endtask : t_refuse
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      interface_mode = m[1:0];
      tick(2);
      chk({8'h0, port_enabled}, {8'h0, m == 3});
    end
  endtask : t_modes
  task automatic t_pins();
    pin_or_port_config_select = 1'b1;
    pins = 4'hB;
    tick(10);
    chk({8'h0, port_enabled}, 9'h000);
    chk({6'h0, input_range, power_down}, 9'h005);
    chk({8'h0, straight_binary}, 9'h001);
    wr(9'h1C4, 9, 1'b0);
    chk({7'h0, input_range}, 9'h002);
    pin_or_port_config_select = 1'b0;
    tick(2);
    pins = 4'h4;
    tick(10);
    chk({6'h0, input_range, power_down}, 9'h005);
  endtask : t_pins
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    interface_mode = 2'h3;
    pin_or_port_config_select = 1'b0;
    clock_invert_select = 1'b0;
    pins = 4'h0;
    tick(12);
    reset = 1'b0;
    chk(converter_setup_q, 9'h000);
    t_serial();
    t_refuse();
    t_modes();
    t_pins();
    reset = 1'b1;
    tick(2);
    chk(converter_setup_q, 9'h000);
    reset = 1'b0;
    tick(2);
    give_verdict();
  end
endmodule : test_adc_serial_config_port
